//--- verilog/timed_periodic_interrupt_unit.sv
// Periodic interrupt unit with index and overflow save and restore.
// Assumes the processor core signals scan end, routine entry and exit,
// and the duration of its instructions in cycles.
//
// Decided for this implementation: the plain strobed port.
`default_nettype none
module timed_periodic_interrupt_unit
    import tpi_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES,
    parameter int POLL_LEN = POLL_CYCLES
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Processor status
    input wire logic remote_run_mode,
    input wire logic scan_end,
    input wire logic instr_busy,
    input wire logic irq_enter,
    input wire logic irq_exit,
    input wire logic fast_pulse_counter_irq,
    input wire logic fault_irq,
    input wire logic overflow_set,
    // Core-side updates of the index register
    input wire logic index_wr,
    input wire logic [15:0] index_wdata,
    // Outputs
    output logic [15:0] index_value,
    output logic timed_periodic_interrupt,
    output logic poll_req,
    output logic irq
);
    reg_req_s req;
    run_e run_r, run_nxt;
    logic [15:0] index_r, index_nxt, index_save_r, index_save_nxt;
    logic [15:0] setpoint_r, setpoint_nxt;
    logic ovf_r, ovf_nxt, ovf_save_r, ovf_save_nxt;
    logic [3:0] status_r, status_nxt, mask_r, mask_nxt, events;
    logic armed_r, armed_nxt, wait_scan_r, wait_scan_nxt, restart;
    logic [15:0] rdata_r, rdata_nxt;
    logic tpi_r, tpi_nxt, poll_r, poll_nxt, irq_r, irq_nxt;
    logic [$clog2(POLL_LEN+1)-1:0] busy_r, busy_nxt;
    logic expire, pending;

    function automatic logic hit(input reg_req_s r, input logic [7:0] a);
        hit = r.wr && r.addr == a;
    endfunction

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    interval_timer #(.TICK_LEN(TICK_LEN)) interval_timer_inst (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .setpoint(setpoint_r[7:0]),
        .run(armed_r && !wait_scan_r),
        .restart(restart),
        .expire(expire)
    );

    always_comb
    begin
        events = {fault_irq, fast_pulse_counter_irq, 1'b0, expire};
        // Only enabled sources count as pending for the poll
        pending = |((status_r | events) & mask_r);
        restart = 1'b0;
        run_nxt = run_r;
        index_nxt = index_r;
        index_save_nxt = index_save_r;
        setpoint_nxt = setpoint_r;
        ovf_nxt = ovf_r | overflow_set;
        ovf_save_nxt = ovf_save_r;
        armed_nxt = armed_r;
        wait_scan_nxt = wait_scan_r;
        mask_nxt = mask_r;
        tpi_nxt = expire;
        if (index_wr)
            index_nxt = index_wdata;
        if (hit(req, ADDR_INDEX))
            index_nxt = req.wdata;
        // Setpoint write: a rewrite of the same value each scan must not reset timing
        if (hit(req, ADDR_SETPOINT) && req.wdata[7:0] != setpoint_r[7:0])
        begin
            setpoint_nxt = {8'h00, req.wdata[7:0]};
            armed_nxt = req.wdata[7:0] != 8'h00;
            restart = 1'b1;
            wait_scan_nxt = remote_run_mode && req.wdata[7:0] != 8'h00;
        end
        else if (wait_scan_r && scan_end)
        begin
            wait_scan_nxt = 1'b0;
            restart = 1'b1;
        end
        if (hit(req, ADDR_MASK))
            mask_nxt = req.wdata[3:0];
        if (hit(req, ADDR_OVERFLOW))
            ovf_nxt = req.wdata[0] | overflow_set;
        unique case (run_r)
            RUN_NORMAL:
                if (irq_enter || fast_pulse_counter_irq || fault_irq)
                begin
                    index_save_nxt = index_r;
                    ovf_save_nxt = ovf_r;
                    run_nxt = RUN_IRQ;
                end
            RUN_IRQ:
                if (irq_exit)
                    run_nxt = RUN_RESUME;
            RUN_RESUME:
            begin
                index_nxt = index_save_r;
                ovf_nxt = ovf_save_r;
                run_nxt = RUN_NORMAL;
            end
            default:
                run_nxt = RUN_NORMAL;
        endcase
        // Set wins over write-one-to-clear
        status_nxt = status_r;
        if (hit(req, ADDR_STATUS))
            status_nxt = status_r & ~req.wdata[3:0];
        status_nxt = status_nxt | events | {2'b00, poll_nxt, 1'b0};
        irq_nxt = |(status_nxt & mask_nxt);
    end

    // Long instruction: poll once the 15 us mark is passed
    always_comb
    begin
        busy_nxt = busy_r;
        poll_nxt = 1'b0;
        if (!instr_busy)
            busy_nxt = '0;
        else if (busy_r != ($clog2(POLL_LEN+1))'(POLL_LEN))
            busy_nxt = busy_r + 1'b1;
        else
            poll_nxt = pending;
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            busy_r <= '0;
            poll_r <= 1'b0;
        end
        else
        begin
            busy_r <= busy_nxt;
            poll_r <= poll_nxt;
        end
    end

    // Read data stands one cycle only, zero otherwise
    always_comb
    begin
        rdata_nxt = RST_WORD;
        if (req.rd)
        begin
            unique case (req.addr)
                ADDR_INDEX: rdata_nxt = index_r;
                ADDR_SETPOINT: rdata_nxt = setpoint_r;
                ADDR_STATUS: rdata_nxt = {12'h000, status_r};
                ADDR_MASK: rdata_nxt = {12'h000, mask_r};
                ADDR_OVERFLOW: rdata_nxt = {15'h0000, ovf_r};
                ADDR_CONTROL: rdata_nxt = {13'h0000, wait_scan_r, armed_r, run_r == RUN_IRQ};
                default: rdata_nxt = RST_WORD;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            rdata_r <= RST_WORD;
        else
            rdata_r <= rdata_nxt;
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            run_r <= RUN_NORMAL;
            index_r <= RST_WORD;
            index_save_r <= RST_WORD;
            setpoint_r <= RST_WORD;
            ovf_r <= 1'b0;
            ovf_save_r <= 1'b0;
            armed_r <= 1'b0;
            wait_scan_r <= 1'b0;
            status_r <= RST_FLAGS;
            mask_r <= RST_FLAGS;
            tpi_r <= 1'b0;
            irq_r <= 1'b0;
        end
        else
        begin
            run_r <= run_nxt;
            index_r <= index_nxt;
            index_save_r <= index_save_nxt;
            setpoint_r <= setpoint_nxt;
            ovf_r <= ovf_nxt;
            ovf_save_r <= ovf_save_nxt;
            armed_r <= armed_nxt;
            wait_scan_r <= wait_scan_nxt;
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            tpi_r <= tpi_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign index_value = index_r;
    assign timed_periodic_interrupt = tpi_r;
    assign poll_req = poll_r;
    assign irq = irq_r;
endmodule
`default_nettype wire

//--- verilog/tpi_pkg.sv
// Constants, types and register map of the timed periodic interrupt unit.
// Assumes a 20 MHz mclk and a synchronous active-high reset.
`default_nettype none
package tpi_pkg;
    localparam int CLK_HZ = 20000000;
    localparam int TICK_MS = 10;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int POLL_US = 15;
    localparam int POLL_CYCLES = (CLK_HZ / 1000000) * POLL_US;
    localparam logic [7:0] ADDR_INDEX = 8'h18;
    localparam logic [7:0] ADDR_SETPOINT = 8'h1E;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    localparam logic [7:0] ADDR_MASK = 8'h22;
    localparam logic [7:0] ADDR_OVERFLOW = 8'h24;
    localparam logic [7:0] ADDR_CONTROL = 8'h26;
    localparam int ST_TIMED = 0;
    localparam int ST_POLL = 1;
    localparam int ST_FAST = 2;
    localparam int ST_FAULT = 3;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [3:0] RST_FLAGS = 4'h0;

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    typedef enum logic [1:0] {
        RUN_NORMAL = 2'b00,
        RUN_IRQ = 2'b01,
        RUN_RESUME = 2'b11
    } run_e;
endpackage
`default_nettype wire

//--- verilog/interval_timer.sv
// Divides mclk to 10 ms ticks and counts setpoint ticks.
// Assumes restart is pulsed whenever counting must begin afresh.
`default_nettype none
module interval_timer
    import tpi_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Control
    input wire logic [7:0] setpoint,
    input wire logic run,
    input wire logic restart,
    // Result
    output logic expire
);
    logic [$clog2(TICK_LEN)-1:0] pre_r, pre_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic exp_r, exp_nxt;

    always_comb
    begin
        pre_nxt = pre_r;
        cnt_nxt = cnt_r;
        exp_nxt = 1'b0;
        if (restart || !run || setpoint == 8'h00)
        begin
            pre_nxt = '0;
            cnt_nxt = 8'h00;
        end
        else if (pre_r == ($clog2(TICK_LEN))'(TICK_LEN - 1))
        begin
            pre_nxt = '0;
            if (cnt_r + 8'h01 >= setpoint)
            begin
                cnt_nxt = 8'h00;
                exp_nxt = 1'b1;
            end
            else
            begin
                cnt_nxt = cnt_r + 8'h01;
            end
        end
        else
        begin
            pre_nxt = pre_r + 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            pre_r <= '0;
            cnt_r <= 8'h00;
            exp_r <= 1'b0;
        end
        else
        begin
            pre_r <= pre_nxt;
            cnt_r <= cnt_nxt;
            exp_r <= exp_nxt;
        end
    end

    assign expire = exp_r;
endmodule
`default_nettype wire

//--- verification/timed_periodic_interrupt_unit_properties.sv
// Port-level checks of the timed periodic interrupt unit.
// Assumes TICK_LEN of at least 10 and POLL_LEN of at least 4.
`default_nettype none
module tpi_properties
    import tpi_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // Core side and outputs
    input wire logic instr_busy,
    input wire logic index_wr,
    input wire logic irq_exit,
    input wire logic [15:0] index_value,
    input wire logic timed_periodic_interrupt,
    input wire logic poll_req,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data not zero outside a read");
    a_setpoint_upper: assert property (reg_rd && reg_addr == ADDR_SETPOINT |=> reg_rdata[15:8] == 8'h00)
        else $error("setpoint upper byte not zero");
    a_setpoint_back: assert property ((reg_wr && reg_addr == ADDR_SETPOINT) ##2
        (reg_rd && reg_addr == ADDR_SETPOINT) |=> reg_rdata[7:0] == 8'($past(reg_wdata, 3)))
        else $error("setpoint read back differs");
    a_index_read: assert property (reg_rd && reg_addr == ADDR_INDEX |=> reg_rdata == $past(index_value))
        else $error("index read differs from index output");
    a_index_write: assert property (reg_wr && reg_addr == ADDR_INDEX && !index_wr && !irq_exit
        && !$past(irq_exit) |=> index_value == $past(reg_wdata))
        else $error("index write not taken");
    a_tick_single: assert property (timed_periodic_interrupt |=> !timed_periodic_interrupt [*8])
        else $error("periodic pulses too close");
    a_poll_busy: assert property (poll_req |-> $past(instr_busy) && $past(instr_busy, 3))
        else $error("poll without a long instruction");
    a_mask_off: assert property (reg_wr && reg_addr == ADDR_MASK && reg_wdata == 16'h0000 |-> ##3 !irq)
        else $error("irq high with mask cleared");
    cover property (timed_periodic_interrupt);
    cover property (poll_req);
    cover property (irq_exit);
endmodule
bind timed_periodic_interrupt_unit tpi_properties tpi_properties_inst (
    .mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .instr_busy,
    .index_wr, .irq_exit, .index_value, .timed_periodic_interrupt, .poll_req, .irq
);
`default_nettype wire

//--- verification/timed_periodic_interrupt_unit_test.sv
// Self-checking bench of the timed periodic interrupt unit.
// Short tick and poll lengths keep the run brief.
`default_nettype none
module timed_periodic_interrupt_unit_test
    import tpi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TL = 10;
    localparam int PL = 4;
    logic mclk, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, remote_run_mode = 1'b0, instr_busy = 1'b0;
    logic timed_periodic_interrupt, poll_req, irq;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, index_wdata = 16'h0000, reg_rdata, index_value, v;
    // Event pulses: enter, exit, fast, fault, overflow, scan end, index write
    logic [6:0] ev = 7'h00;
    int miscompares = 0, n_checks = 0, n;
    timed_periodic_interrupt_unit #(.TICK_LEN(TL), .POLL_LEN(PL)) timed_periodic_interrupt_unit_inst (
        .mclk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .remote_run_mode, .instr_busy,
        .scan_end(ev[5]), .irq_enter(ev[0]), .irq_exit(ev[1]), .fast_pulse_counter_irq(ev[2]),
        .fault_irq(ev[3]), .overflow_set(ev[4]), .index_wr(ev[6]), .index_wdata, .index_value,
        .timed_periodic_interrupt, .poll_req, .irq
    );
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task automatic chk(string s, logic [15:0] e, logic [15:0] g);
        n_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", s, e, g);
        end
    endtask
    // Gap cycle after each strobe so no signal is set twice in a step
    task automatic wr(logic [7:0] a, logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
        v = reg_rdata;
    endtask
    task automatic pulse(int k);
        ev[k] <= 1'b1;
        @(posedge mclk);
        ev[k] <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wait_tick(int lim);
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
            if (n > lim)
            begin
                miscompares++;
                $display("unexpected pulse wait: expected %0d seen %0d", lim, n);
                results();
            end
        end
        while (timed_periodic_interrupt !== 1'b1);
    endtask
    // Counts periodic pulses, or poll pulses when p is set
    task automatic count_ticks(int c, bit p = 1'b0);
        n = 0;
        repeat (c)
        begin
            @(posedge mclk);
            n += ((p ? poll_req : timed_periodic_interrupt) === 1'b1);
        end
    endtask
    task t_regs;
        wr(ADDR_SETPOINT, 16'h01FF);
        rd(ADDR_SETPOINT);
        chk("setpoint", 16'h00FF, v);
        wr(ADDR_INDEX, 16'hA5C3);
        rd(ADDR_INDEX);
        chk("index", 16'hA5C3, v);
        rd(8'h40);
        chk("unmapped", 16'h0000, v);
        wr(ADDR_SETPOINT, 16'h0000);
        $display("t_regs done");
    endtask
    task t_period;
        wr(ADDR_MASK, 16'h000F);
        wr(ADDR_SETPOINT, 16'h0002);
        wait_tick(40);
        wait_tick(40);
        chk("period", 2 * TL, n);
        chk("irq set", 1, irq);
        rd(ADDR_STATUS);
        chk("status", 16'h0001, v);
        instr_busy <= 1'b1;
        count_ticks(8, 1'b1);
        chk("poll", 8 - PL - 1, n);
        instr_busy <= 1'b0;
        wr(ADDR_SETPOINT, 16'h0000);
        wr(ADDR_MASK, 16'h0000);
        repeat (2) @(posedge mclk);
        chk("irq masked", 0, irq);
        wr(ADDR_STATUS, 16'h000F);
        wr(ADDR_MASK, 16'h000F);
        repeat (3) @(posedge mclk);
        chk("irq cleared", 0, irq);
        count_ticks(60);
        chk("disabled", 0, n);
        $display("t_period done");
    endtask
    task t_remote;
        remote_run_mode <= 1'b1;
        wr(ADDR_SETPOINT, 16'h0001);
        rd(ADDR_CONTROL);
        chk("control", 16'h0006, v);
        count_ticks(30);
        chk("before scan end", 0, n);
        pulse(5);
        wait_tick(30);
        chk("after scan end", 1, n >= TL - 1 && n <= TL + 4);
        wr(ADDR_SETPOINT, 16'h0000);
        remote_run_mode <= 1'b0;
        $display("t_remote done");
    endtask
    task t_restart;
        wr(ADDR_SETPOINT, 16'h0003);
        repeat (15) @(posedge mclk);
        wr(ADDR_SETPOINT, 16'h0002);
        wait_tick(40);
        chk("restart", 1, n >= 2 * TL - 2 && n <= 2 * TL + 2);
        wr(ADDR_SETPOINT, 16'h0000);
        $display("t_restart done");
    endtask
    task t_restore;
        for (int k = 0; k < 4; k++)
        begin
            if (k == 1)
                continue;
            wr(ADDR_INDEX, 16'(16'h1230 + k));
            pulse(4);
            pulse(k);
            index_wdata <= 16'hFFFF;
            pulse(6);
            wr(ADDR_OVERFLOW, 16'h0000);
            pulse(1);
            @(posedge mclk);
            chk("index restore", 16'(16'h1230 + k), index_value);
            rd(ADDR_OVERFLOW);
            chk("overflow restore", 1, v[0]);
        end
        $display("t_restore done");
    endtask
    // Same-value rewrites each scan must leave the period untouched
    task t_rewrite;
        wr(ADDR_SETPOINT, 16'h0002);
        wait_tick(40);
        repeat (3) wr(ADDR_SETPOINT, 16'h0002);
        wait_tick(40);
        chk("rewrite", 2 * TL - 6, n);
        wr(ADDR_SETPOINT, 16'h0000);
        $display("t_rewrite done");
    endtask
    task results;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        t_regs();
        t_period();
        t_remote();
        t_restart();
        t_rewrite();
        t_restore();
        results();
    end
endmodule
`default_nettype wire
